// File: hdl/reg_file_pkg.sv
// Notes on behaviour
// - Accept 8-bit and 4-bit operand addresses
// - Sixteen working groups of sixteen registers
// - Pointer upper nibble picks working group
// - Pointer lower nibble picks expanded bank
// - Pointer at FDh, read/write, reset zero
// - 16 addresses (00h-0Fh) per expanded bank, sixteen banks
// - Bank F holds four config registers
// - Bank 0: ports, general, control registers
// - E0h-EFh refused for plain direct addressing
// - General registers survive reset, no init
// - Stack in general registers, low pointer
// - Stack pointer bytes cleared on reset, recovery
// - Protect blocks writes 80h-EFh when active
// - Mask register bit 6 enables protection
package reg_file_pkg;

  typedef enum logic [1:0] {
    MODE_DIRECT   = 2'b00,
    MODE_INDIRECT = 2'b01,
    MODE_WORKING  = 2'b10
  } addr_mode_type;

  localparam logic [7:0] INTERRUPT_MASK_INDEX   = 8'hfb;
  localparam logic [7:0] REGISTER_POINTER_INDEX = 8'hfd;
  localparam logic [7:0] STACK_HIGH_INDEX       = 8'hfe;
  localparam logic [7:0] STACK_LOW_INDEX        = 8'hff;
  localparam logic [7:0] REGISTER_POINTER_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET          = 8'h00;
  localparam logic [7:0] CONFIG_RESET           = 8'h00;
  localparam logic [7:0] STACK_RESET            = 8'h00;

  localparam logic [3:0] CONTROL_GROUP      = 4'hf;
  localparam logic [3:0] RESTRICTED_GROUP   = 4'he;
  localparam logic [3:0] CONFIG_BANK        = 4'hf;
  localparam logic [3:0] BASE_BANK          = 4'h0;
  localparam logic [3:0] EXPANDED_GROUP     = 4'h0;
  localparam int         CONFIG_COUNT       = 4;
  localparam logic [7:0] PROTECT_LOW        = 8'h80;
  localparam logic [7:0] PROTECT_HIGH       = 8'hef;
  localparam int         PROTECT_ENABLE_BIT = 6;

  localparam logic [9:0] AXI_STATUS_INDEX   = 10'h100;
  localparam int         STATUS_PROTECT_BIT = 8;
  localparam int         STATUS_REFUSED_BIT = 9;
  localparam logic [1:0] RESP_OKAY          = 2'b00;
  localparam logic [1:0] RESP_SLVERR        = 2'b10;

endpackage

// File: hdl/access_if.sv
`timescale 1ns/1ps
interface access_if;
  import reg_file_pkg::*;
  addr_mode_type mode;
  logic [7:0]    addr;
  logic          write;
  logic [7:0]    pointer;
  logic          protect_on;
  logic [7:0]    full_addr;
  logic          expanded;
  logic          refused;
  logic          blocked;
  logic          store_we;
  logic [7:0]    store_wdata;
  logic [7:0]    store_rdata;

  modport owner (output mode, addr, write, pointer, protect_on, store_we, store_wdata,
                 input full_addr, expanded, refused, blocked, store_rdata);
  modport resolver (input mode, addr, write, pointer, protect_on,
                    output full_addr, expanded, refused, blocked);
  modport store (input full_addr, store_we, store_wdata, output store_rdata);
endinterface

// File: hdl/addr_resolver.sv
`timescale 1ns/1ps
module addr_resolver
  import reg_file_pkg::*;
(
  access_if.resolver acc
);

  always_comb
  begin
    if (acc.mode == MODE_WORKING)
    begin
      acc.full_addr = {acc.pointer[7:4], acc.addr[3:0]};
    end
    else
    begin
      acc.full_addr = acc.addr;
    end
    // Non-zero bank overlays the lowest group
    acc.expanded = (acc.pointer[3:0] != BASE_BANK) &&
                   (acc.full_addr[7:4] == EXPANDED_GROUP);
    acc.refused  = (acc.mode == MODE_DIRECT) &&
                   (acc.addr[7:4] == RESTRICTED_GROUP);
    acc.blocked  = acc.write && acc.protect_on && !acc.expanded &&
                   (acc.full_addr >= PROTECT_LOW) &&
                   (acc.full_addr <= PROTECT_HIGH);
  end

endmodule

// File: hdl/gpr_store.sv
`timescale 1ns/1ps
module gpr_store
  import reg_file_pkg::*;
(
  input  wire logic aclk,
  access_if.store   acc
);

  // No reset and no initial value: contents persist across reset
  logic [7:0] mem [256];

  always_ff @(posedge aclk)
  begin
    if (acc.store_we)
    begin
      mem[acc.full_addr] <= acc.store_wdata;
    end
  end

  assign acc.store_rdata = mem[acc.full_addr];

endmodule

// File: hdl/banked_register_file.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module banked_register_file
  import reg_file_pkg::*;
#(
  parameter bit RAM_PROTECT_OPTION = 1'b1
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        op_req,
  input  wire logic        op_write,
  input  wire logic [1:0]  op_mode,
  input  wire logic [7:0]  op_addr,
  input  wire logic [7:0]  op_wdata,
  output logic [7:0]       op_rdata_q,
  output logic             op_done_q,
  output logic             op_refused_q,
  output logic [7:0]       register_pointer_q,
  output logic             protect_active_q,
  input  wire logic        stop_recovery
);

  access_if acc ();

  addr_resolver resolver_inst (
    .acc (acc)
  );

  gpr_store store_inst (
    .aclk (aclk),
    .acc  (acc)
  );

  // Control group F0h-FFh and bank F config registers
  logic [7:0] ctrl_q [16];
  logic [7:0] ctrl_d [16];
  logic [7:0] cfg_q  [CONFIG_COUNT];
  logic [7:0] cfg_d  [CONFIG_COUNT];

  logic       stop_meta_q;
  logic       stop_sync_q;

  logic [9:0] aw_index_q;
  logic [9:0] aw_index_d;
  logic       aw_full_q;
  logic       aw_full_d;
  logic [31:0] w_data_q;
  logic [31:0] w_data_d;
  logic       w_lane_q;
  logic       w_lane_d;
  logic       w_full_q;
  logic       w_full_d;
  logic [9:0] ar_index_q;
  logic [9:0] ar_index_d;
  logic       ar_full_q;
  logic       ar_full_d;
  logic       awready_d;
  logic       wready_d;
  logic       bvalid_d;
  logic [1:0] bresp_d;
  logic       arready_d;
  logic       rvalid_d;
  logic [31:0] rdata_d;
  logic [1:0] rresp_d;
  logic [7:0] op_rdata_d;
  logic       op_done_d;
  logic       op_refused_d;
  logic       refused_seen_q;
  logic       refused_seen_d;
  logic       protect_active_d;

  logic       axi_wr_go;
  logic       axi_rd_go;
  logic       acc_go;
  logic       acc_in_space;
  logic       status_hit;
  logic       write_ok;
  logic [7:0] read_value;
  logic [9:0] acc_index;

  // Single access path; the processor always wins, bus waits its turn
  always_comb
  begin
    axi_wr_go    = aw_full_q && w_full_q && !bvalid_q_hold() && !op_req;
    axi_rd_go    = ar_full_q && !rvalid && !op_req && !axi_wr_go;
    acc_index    = axi_wr_go ? aw_index_q : ar_index_q;
    acc_in_space = op_req || (acc_index[9:8] == 2'b00);
    status_hit   = !op_req && (acc_index == AXI_STATUS_INDEX);
    acc_go       = op_req || ((axi_wr_go || axi_rd_go) && acc_in_space);
    acc.pointer    = ctrl_q[REGISTER_POINTER_INDEX[3:0]];
    acc.protect_on = RAM_PROTECT_OPTION &&
                     ctrl_q[INTERRUPT_MASK_INDEX[3:0]][PROTECT_ENABLE_BIT];
    if (op_req)
    begin
      acc.mode        = addr_mode_type'(op_mode);
      acc.addr        = op_addr;
      acc.write       = op_write;
      acc.store_wdata = op_wdata;
    end
    else
    begin
      // Bus sees the space as indirect so E0h-EFh stays reachable
      acc.mode        = MODE_INDIRECT;
      acc.addr        = acc_index[7:0];
      acc.write       = axi_wr_go && w_lane_q;
      acc.store_wdata = w_data_q[7:0];
    end
    write_ok = acc_go && acc.write && !acc.refused && !acc.blocked;
  end

  function automatic logic bvalid_q_hold();
    return bvalid;
  endfunction

  // Read data mux and write steering over the three storage kinds
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      ctrl_d[i] = ctrl_q[i];
    end
    for (int i = 0; i < CONFIG_COUNT; i++)
    begin
      cfg_d[i] = cfg_q[i];
    end
    acc.store_we = 1'b0;
    read_value   = 8'h00;
    if (acc.expanded)
    begin
      // Only bank F has real cells; others read zero, writes lost
      if (acc.pointer[3:0] == CONFIG_BANK && acc.full_addr[3:0] < 4'(CONFIG_COUNT))
      begin
        read_value = cfg_q[acc.full_addr[1:0]];
        if (write_ok)
        begin
          cfg_d[acc.full_addr[1:0]] = acc.store_wdata;
        end
      end
    end
    else if (acc.full_addr[7:4] == CONTROL_GROUP)
    begin
      // F0h is not a register; reads zero
      if (acc.full_addr[3:0] != 4'h0)
      begin
        read_value = ctrl_q[acc.full_addr[3:0]];
        if (write_ok)
        begin
          ctrl_d[acc.full_addr[3:0]] = acc.store_wdata;
        end
      end
    end
    else
    begin
      read_value   = acc.store_rdata;
      acc.store_we = write_ok;
    end
    if (acc.refused)
    begin
      read_value = 8'h00;
    end
    // Recovery clears stack pointers after any stored write
    if (stop_sync_q)
    begin
      ctrl_d[STACK_HIGH_INDEX[3:0]] = STACK_RESET;
      ctrl_d[STACK_LOW_INDEX[3:0]]  = STACK_RESET;
    end
  end

  // Bus channel capture and responses
  always_comb
  begin
    aw_index_d = aw_index_q;
    aw_full_d  = aw_full_q;
    w_data_d   = w_data_q;
    w_lane_d   = w_lane_q;
    w_full_d   = w_full_q;
    ar_index_d = ar_index_q;
    ar_full_d  = ar_full_q;
    bvalid_d   = bvalid && !bready;
    bresp_d    = bresp;
    rvalid_d   = rvalid && !rready;
    rdata_d    = rdata;
    rresp_d    = rresp;
    refused_seen_d = refused_seen_q;
    if (awvalid && awready)
    begin
      aw_index_d = awaddr[11:2];
      aw_full_d  = 1'b1;
    end
    if (wvalid && wready)
    begin
      w_data_d = wdata;
      w_lane_d = wstrb[0];
      w_full_d = 1'b1;
    end
    if (arvalid && arready)
    begin
      ar_index_d = araddr[11:2];
      ar_full_d  = 1'b1;
    end
    if (axi_wr_go)
    begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (acc_in_space || status_hit) ? RESP_OKAY : RESP_SLVERR;
      if (status_hit && w_lane_q && w_data_q[STATUS_REFUSED_BIT])
      begin
        refused_seen_d = 1'b0;
      end
    end
    if (axi_rd_go)
    begin
      ar_full_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = (acc_in_space || status_hit) ? RESP_OKAY : RESP_SLVERR;
      rdata_d   = 32'h0000_0000;
      if (status_hit)
      begin
        rdata_d[7:0]               = acc.pointer;
        rdata_d[STATUS_PROTECT_BIT] = acc.protect_on;
        rdata_d[STATUS_REFUSED_BIT] = refused_seen_q;
      end
      else if (acc_in_space)
      begin
        rdata_d[7:0] = read_value;
      end
    end
    // Set wins over a clear in the same cycle
    if (acc_go && acc.write && (acc.refused || acc.blocked))
    begin
      refused_seen_d = 1'b1;
    end
    awready_d = !aw_full_d && !bvalid_d;
    wready_d  = !w_full_d && !bvalid_d;
    arready_d = !ar_full_d && !rvalid_d;
  end

  // Processor answer, one cycle after the request
  always_comb
  begin
    op_done_d        = op_req;
    op_refused_d     = op_req && (acc.refused || acc.blocked);
    op_rdata_d       = op_req ? read_value : op_rdata_q;
    protect_active_d = acc.protect_on;
  end

  always_ff @(posedge aclk)
  begin
    // Recovery input is asynchronous to the core clock
    stop_meta_q <= stop_recovery;
    stop_sync_q <= stop_meta_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 16; i++)
      begin
        ctrl_q[i] <= CONTROL_RESET;
      end
      for (int i = 0; i < CONFIG_COUNT; i++)
      begin
        cfg_q[i] <= CONFIG_RESET;
      end
      aw_index_q         <= 10'h000;
      aw_full_q          <= 1'b0;
      w_data_q           <= 32'h0000_0000;
      w_lane_q           <= 1'b0;
      w_full_q           <= 1'b0;
      ar_index_q         <= 10'h000;
      ar_full_q          <= 1'b0;
      awready            <= 1'b0;
      wready             <= 1'b0;
      bvalid             <= 1'b0;
      bresp              <= RESP_OKAY;
      arready            <= 1'b0;
      rvalid             <= 1'b0;
      rdata              <= 32'h0000_0000;
      rresp              <= RESP_OKAY;
      op_rdata_q         <= 8'h00;
      op_done_q          <= 1'b0;
      op_refused_q       <= 1'b0;
      refused_seen_q     <= 1'b0;
      protect_active_q   <= 1'b0;
      register_pointer_q <= REGISTER_POINTER_RESET;
    end
    else
    begin
      for (int i = 0; i < 16; i++)
      begin
        ctrl_q[i] <= ctrl_d[i];
      end
      for (int i = 0; i < CONFIG_COUNT; i++)
      begin
        cfg_q[i] <= cfg_d[i];
      end
      aw_index_q         <= aw_index_d;
      aw_full_q          <= aw_full_d;
      w_data_q           <= w_data_d;
      w_lane_q           <= w_lane_d;
      w_full_q           <= w_full_d;
      ar_index_q         <= ar_index_d;
      ar_full_q          <= ar_full_d;
      awready            <= awready_d;
      wready             <= wready_d;
      bvalid             <= bvalid_d;
      bresp              <= bresp_d;
      arready            <= arready_d;
      rvalid             <= rvalid_d;
      rdata              <= rdata_d;
      rresp              <= rresp_d;
      op_rdata_q         <= op_rdata_d;
      op_done_q          <= op_done_d;
      op_refused_q       <= op_refused_d;
      refused_seen_q     <= refused_seen_d;
      protect_active_q   <= protect_active_d;
      register_pointer_q <= ctrl_d[REGISTER_POINTER_INDEX[3:0]];
    end
  end

endmodule

// File: verif/cpu_port_model.sv
`timescale 1ns/1ps
module cpu_port_model
  import reg_file_pkg::*;
(
  input  wire logic       aclk,
  output logic            op_req,
  output logic            op_write,
  output logic [1:0]      op_mode,
  output logic [7:0]      op_addr,
  output logic [7:0]      op_wdata,
  input  wire logic [7:0] op_rdata_q,
  input  wire logic       op_done_q,
  input  wire logic       op_refused_q
);
  initial
  begin
    op_req = 1'b0;
    op_write = 1'b0;
    op_mode = 2'b00;
    op_addr = 8'h00;
    op_wdata = 8'h00;
  end

  // Idle gaps vary pacing; operand lines scrambled once released
  task automatic access(input logic wr, input logic [1:0] md, input logic [7:0] a, dt,
                        input int gap, output logic [7:0] rd, output logic rf, dn);
    repeat (gap) @(posedge aclk);
    @(posedge aclk);
    op_req <= 1'b1;
    op_write <= wr;
    op_mode <= md;
    op_addr <= a;
    op_wdata <= dt;
    @(posedge aclk);
    op_req <= 1'b0;
    op_addr <= ~a;
    op_wdata <= ~dt;
    @(negedge aclk);
    rd = op_rdata_q;
    rf = op_refused_q;
    dn = op_done_q;
  endtask
endmodule

// File: verif/banked_register_file_checker.sv
`timescale 1ns/1ps
module banked_register_file_checker
  import reg_file_pkg::*;
#(
  parameter bit RAM_PROTECT_OPTION = 1'b1
)
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       op_req,
  input wire logic       op_write,
  input wire logic [1:0] op_mode,
  input wire logic [7:0] op_addr,
  input wire logic [7:0] op_wdata,
  input wire logic       op_done_q,
  input wire logic       op_refused_q,
  input wire logic [7:0] register_pointer_q,
  input wire logic       protect_active_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  done_pulse_a: assert property (op_req |=> op_done_q)
    else $error("request without done");
  done_idle_a: assert property (!op_req |=> !op_done_q)
    else $error("done without request");
  direct_refuse_a: assert property (op_req && op_mode == 2'b00
    && op_addr[7:4] == RESTRICTED_GROUP |=> op_refused_q) else $error("direct E0 not refused");
  working_read_a: assert property (op_req && !op_write && op_mode == 2'b10
    |=> !op_refused_q) else $error("working read refused");
  ptr_reset_a: assert property ($rose(aresetn)
    |-> register_pointer_q == REGISTER_POINTER_RESET) else $error("pointer not reset");
  ptr_write_a: assert property (op_req && op_write && op_mode == 2'b00
    && op_addr == REGISTER_POINTER_INDEX |=> register_pointer_q == $past(op_wdata))
    else $error("pointer write lost");
  protect_block_a: assert property (protect_active_q && op_req && op_write
    && op_mode == 2'b01 && op_addr inside {[PROTECT_LOW:PROTECT_HIGH]} |=> op_refused_q)
    else $error("protected write not refused");
  protect_off_a: assert property (!protect_active_q && op_req && op_mode == 2'b01
    |=> !op_refused_q) else $error("indirect refused without protect");
  protect_set_a: assert property (op_req && op_write && op_mode == 2'b00
    && op_addr == INTERRUPT_MASK_INDEX |-> ##2 protect_active_q
    == (RAM_PROTECT_OPTION && $past(op_wdata[PROTECT_ENABLE_BIT], 2)))
    else $error("protect bit not followed");
endmodule

bind banked_register_file banked_register_file_checker #(
  .RAM_PROTECT_OPTION(RAM_PROTECT_OPTION)
) banked_register_file_checker_i (.aclk, .aresetn, .op_req, .op_write, .op_mode, .op_addr,
  .op_wdata, .op_done_q, .op_refused_q, .register_pointer_q, .protect_active_q);

// File: verif/test_banked_register_file.sv
`timescale 1ns/1ps
module test_banked_register_file;
  import reg_file_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, stop_recovery = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, op_req, op_write;
  logic        op_done_q, op_refused_q, protect_active_q, rf_v;
  logic [1:0]  bresp, rresp, op_mode, resp;
  logic [31:0] rdata, d32;
  logic [7:0]  op_addr, op_wdata, op_rdata_q, register_pointer_q, rd_v, a, d, g, ka, kd;
  int          failures = 0, num_checks = 0;

  always #20 aclk = ~aclk;

  banked_register_file banked_register_file_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .op_req, .op_write, .op_mode, .op_addr, .op_wdata,
    .op_rdata_q, .op_done_q, .op_refused_q, .register_pointer_q, .protect_active_q,
    .stop_recovery);
  cpu_port_model cpu_port_model_i (.aclk, .op_req, .op_write, .op_mode, .op_addr, .op_wdata,
    .op_rdata_q, .op_done_q, .op_refused_q);

  task automatic close_out;
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  function automatic logic [7:0] work_addr(input logic [7:0] rp, n);
    return {rp[7:4], n[3:0]};
  endfunction

  task automatic cpu(input logic wr, input addr_mode_type md, input logic [7:0] ad, dt);
    logic dn;
    cpu_port_model_i.access(wr, md, ad, dt, $urandom_range(0, 2), rd_v, rf_v, dn);
    chk(dn, 1'b1);
  endtask

  task automatic rd_chk(input addr_mode_type md, input logic [7:0] ad, e, input logic ef);
    cpu(1'b0, md, ad, 8'h00);
    chk(rd_v, e);
    chk(rf_v, ef);
  endtask

  task automatic axi_wr(input logic [31:0] ad, dt, input logic [3:0] sb);
    logic ah, wh;
    ah = 1'b0;
    wh = 1'b0;
    @(posedge aclk);
    awaddr <= ad;
    awvalid <= 1'b1;
    wdata <= dt;
    wstrb <= sb;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ah && wh))
    begin
      @(posedge aclk);
      if (awready && !ah)
      begin
        ah = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !wh)
      begin
        wh = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] ad);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d32 = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic pulse_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    close_out;
  end

  initial
  begin
    void'($urandom(32'h6a50_15d3));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(32'h0000_03f4);
    chk(d32, 32'h0000_0000);
    rd_chk(MODE_DIRECT, STACK_LOW_INDEX, STACK_RESET, 1'b0);
    rd_chk(MODE_DIRECT, STACK_HIGH_INDEX, STACK_RESET, 1'b0);
    repeat (6)
    begin
      g = 8'($urandom_range(1, 13)) << 4;
      d = 8'($urandom);
      a = 8'($urandom);
      cpu(1'b1, MODE_DIRECT, REGISTER_POINTER_INDEX, g);
      cpu(1'b1, MODE_WORKING, a, d);
      rd_chk(MODE_DIRECT, work_addr(g, a), d, 1'b0);
      rd_chk(MODE_WORKING, a, d, 1'b0);
    end
    cpu(1'b1, MODE_DIRECT, REGISTER_POINTER_INDEX, 8'h00);
    repeat (8)
    begin
      // Kept below 7Fh so the later fixed writes never land on it
      ka = 8'($urandom_range(16, 111));
      kd = 8'($urandom);
      cpu(1'b1, MODE_DIRECT, ka, kd);
      rd_chk(MODE_INDIRECT, ka, kd, 1'b0);
    end
    cpu(1'b1, MODE_DIRECT, REGISTER_POINTER_INDEX, 8'he0);
    cpu(1'b1, MODE_WORKING, 8'h05, 8'ha5);
    rd_chk(MODE_DIRECT, 8'he5, 8'h00, 1'b1);
    cpu(1'b1, MODE_DIRECT, 8'he5, 8'h3c);
    chk(rf_v, 1'b1);
    rd_chk(MODE_INDIRECT, 8'he5, 8'ha5, 1'b0);
    cpu(1'b1, MODE_DIRECT, 8'h02, 8'h3c);
    cpu(1'b1, MODE_DIRECT, REGISTER_POINTER_INDEX, 8'h0f);
    for (int i = 0; i < 5; i++)
      cpu(1'b1, MODE_INDIRECT, 8'(i), 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 5; i++)
      rd_chk(MODE_INDIRECT, 8'(i), i < CONFIG_COUNT ? 8'(8'h11 * (i + 1)) : 8'h00, 1'b0);
    cpu(1'b1, MODE_DIRECT, REGISTER_POINTER_INDEX, 8'h05);
    rd_chk(MODE_INDIRECT, 8'h01, 8'h00, 1'b0);
    cpu(1'b1, MODE_DIRECT, REGISTER_POINTER_INDEX, 8'h00);
    rd_chk(MODE_DIRECT, 8'h02, 8'h3c, 1'b0);
    cpu(1'b1, MODE_DIRECT, 8'h90, 8'h12);
    cpu(1'b1, MODE_DIRECT, INTERRUPT_MASK_INDEX, 8'h40);
    cpu(1'b1, MODE_DIRECT, 8'h90, 8'hee);
    chk(rf_v, 1'b1);
    chk(protect_active_q, 1'b1);
    rd_chk(MODE_DIRECT, 8'h90, 8'h12, 1'b0);
    cpu(1'b1, MODE_INDIRECT, PROTECT_HIGH, 8'h01);
    chk(rf_v, 1'b1);
    cpu(1'b1, MODE_DIRECT, 8'h7f, 8'h5e);
    rd_chk(MODE_DIRECT, 8'h7f, 8'h5e, 1'b0);
    cpu(1'b1, MODE_DIRECT, REGISTER_POINTER_INDEX, 8'h20);
    chk(rf_v, 1'b0);
    cpu(1'b1, MODE_DIRECT, INTERRUPT_MASK_INDEX, 8'h00);
    cpu(1'b1, MODE_DIRECT, 8'h90, 8'hee);
    rd_chk(MODE_DIRECT, 8'h90, 8'hee, 1'b0);
    cpu(1'b1, MODE_DIRECT, STACK_LOW_INDEX, 8'h5a);
    cpu(1'b1, MODE_DIRECT, STACK_HIGH_INDEX, 8'ha5);
    pulse_reset;
    chk(register_pointer_q, REGISTER_POINTER_RESET);
    rd_chk(MODE_DIRECT, ka, kd, 1'b0);
    rd_chk(MODE_DIRECT, STACK_LOW_INDEX, STACK_RESET, 1'b0);
    rd_chk(MODE_DIRECT, STACK_HIGH_INDEX, STACK_RESET, 1'b0);
    cpu(1'b1, MODE_DIRECT, STACK_LOW_INDEX, 8'h77);
    cpu(1'b1, MODE_DIRECT, STACK_HIGH_INDEX, 8'h66);
    @(posedge aclk);
    stop_recovery <= 1'b1;
    repeat (4) @(posedge aclk);
    stop_recovery <= 1'b0;
    repeat (3) @(posedge aclk);
    rd_chk(MODE_DIRECT, STACK_LOW_INDEX, STACK_RESET, 1'b0);
    rd_chk(MODE_DIRECT, STACK_HIGH_INDEX, STACK_RESET, 1'b0);
    g = 8'($urandom);
    axi_wr(32'h0000_03f4, {24'h00_0000, g}, 4'hf);
    chk(resp, RESP_OKAY);
    chk(register_pointer_q, g);
    // Low lane off: the byte must not land
    axi_wr(32'h0000_03f4, {24'h00_0000, ~g}, 4'he);
    chk(resp, RESP_OKAY);
    chk(register_pointer_q, g);
    axi_rd(32'h0000_0400);
    chk(d32[7:0], g);
    axi_rd({22'h00_0000, ka, 2'b00});
    chk(d32, {24'h00_0000, kd});
    axi_wr(32'h0000_0800, 32'hffff_ffff, 4'hf);
    chk(resp, RESP_SLVERR);
    axi_rd(32'h0000_0800);
    chk(resp, RESP_SLVERR);
    chk(d32, 32'h0000_0000);
    close_out;
  end
endmodule
